// File: src/ice_consts.vh
/*
 Constants for the emulator break and memory map logic.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ICE_CONSTS_VH
`define ICE_CONSTS_VH
// Bus widths
`define ADDR_W        20
`define BLK_W         8
`define NBLK          256
// Program memory block is 4K bytes, block index is address bits 19:12
`define BLK_LSB       12
// Chain modes of the downstream comparators
`define ARM_NONE      2'h0
`define ARM_1TO2      2'h1
`define ARM_2TO3      2'h2
`define ARM_1TO2TO3   2'h3
// Qualifier bits: [0] read, [1] write, [2] memory, [3] I/O
`define Q_RD          0
`define Q_WT          1
`define Q_MEM         2
`define Q_IO          3
// Interrupt vector window that also traps system breaks
`define NMI_VEC_LO    20'h00008
`define NMI_VEC_HI    20'h0000b
// Processor state after reset
`define CS_RESET      16'hffff
`define SEG_RESET     16'h0000
`endif

// File: src/map_mem.v
/*
 Block map memory: per 4K block an allocated bit and a slow bit.
 Assumes one clock; read data registered, one cycle latency.
*/
`timescale 1ns/100ps
`include "ice_consts.vh"
module map_mem (
  // Clock and reset
  input  wire                CLK,
  input  wire                RST_N,
  // Lookup port
  input  wire [`BLK_W-1:0]   rd_blk,
  output reg                 rd_alloc_q,
  output reg                 rd_slow_q,
  // Update port
  input  wire                wr_en,
  input  wire [`BLK_W-1:0]   wr_blk,
  input  wire                wr_alloc,
  input  wire                wr_attr_en,
  input  wire                wr_slow,
  input  wire                clr_all
);
  reg [`NBLK-1:0] alloc_q;
  reg [`NBLK-1:0] slow_q;
  // Allocation table; release of all leaves slow bits alone
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      alloc_q <= {`NBLK{1'b0}};
    end else if (clr_all) begin
      alloc_q <= {`NBLK{1'b0}};
    end else if (wr_en) begin
      alloc_q[wr_blk] <= wr_alloc;
    end
  end
  // Slow bits change only on an explicit attribute write
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slow_q <= {`NBLK{1'b0}};
    end else if (wr_en && wr_attr_en) begin
      slow_q[wr_blk] <= wr_slow;
    end
  end
  // Registered read
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_alloc_q <= 1'b0;
      rd_slow_q  <= 1'b0;
    end else begin
      rd_alloc_q <= alloc_q[rd_blk];
      rd_slow_q  <= slow_q[rd_blk];
    end
  end
endmodule // map_mem

// File: src/ice_break_map.v
/*
 Emulator break comparators, program memory map and reset state.
 Assumes bus cycle inputs synchronous to CLK (one strobe per cycle);
 the interrupt and test pins are asynchronous and are synchronised.
*/
`timescale 1ns/100ps
`include "ice_consts.vh"
module ice_break_map (
  // Clock and reset
  input  wire                CLK,
  input  wire                RST_N,
  // Processor bus cycle
  input  wire                BUS_STB,
  input  wire [`ADDR_W-1:0]  BUS_ADDR,
  input  wire                BUS_WR,
  input  wire                BUS_IO,
  input  wire                INTA_CYC,
  // Comparator setup, sel 0..2
  input  wire                BK_WE,
  input  wire [1:0]          BK_SEL,
  input  wire                BK_EN,
  input  wire [`ADDR_W-1:0]  BK_ADDR,
  input  wire [3:0]          BK_QUAL,
  input  wire                BK_ARM,
  input  wire                BK_CLR_TRIG,
  // Memory map setup
  input  wire                MAP_WE,
  input  wire [`BLK_W-1:0]   MAP_BLK,
  input  wire                MAP_ALLOC,
  input  wire                MAP_ATTR_EN,
  input  wire                MAP_SLOW,
  input  wire                MAP_DEAL_ALL,
  // Processor pins
  input  wire                MASKABLE_IRQ_PIN,
  input  wire                NMI_PIN,
  input  wire                TEST_PIN,
  // Break results
  output reg                 BREAK_Q,
  output reg  [`ADDR_W-1:0]  TRACE_ADDR_Q,
  output reg                 TRACE_WR_Q,
  output reg                 TRACE_IO_Q,
  output reg  [2:0]          ARMED_Q,
  // Map results, two cycles after BUS_STB
  output reg                 MAP_HIT_Q,
  output reg                 WAIT_REQ_Q,
  // Reset state of processor registers
  output reg  [15:0]         CODE_SEG_Q,
  output reg  [15:0]         INSTRUCTION_POINTER_Q,
  output reg  [15:0]         DATA_SEGMENT_Q,
  output reg  [15:0]         EXTRA_SEGMENT_Q,
  output reg  [15:0]         STACK_SEG_Q,
  output reg  [15:0]         FLAGS_Q,
  // Observed pins
  output reg                 MASKABLE_IRQ_INPUT_Q,
  output reg                 NMI_IN_Q,
  output reg                 TEST_IN_Q
);
  reg [`ADDR_W-1:0] cmp_addr_q [0:2];
  reg [3:0]         cmp_qual_q [0:2];
  reg [2:0]         cmp_en_q;
  reg [2:0]         cmp_arm_q;  // bit1: second armed by first, bit2: third by second
  reg [2:0]         armed_d;
  reg [2:0]         hit;
  reg [2:0]         fire;
  reg [2:0]         chain;      // bit i: comparator i arms the next one
  reg [2:0]         pin_s1_q;
  reg [2:0]         pin_s2_q;
  reg               stb_q;
  wire              map_alloc;
  wire              map_slow;
  integer           i;
  integer           j;

  // Match of one comparator against the present bus cycle
  function cmp_match;
    input [`ADDR_W-1:0] ca;
    input [3:0]         q;
    input [`ADDR_W-1:0] a;
    input               wr;
    input               io;
    input               inta;
    reg                 dir_ok;
    reg                 spc_ok;
    reg                 vec;
    begin
      dir_ok = wr ? q[`Q_WT] : q[`Q_RD];
      spc_ok = io ? q[`Q_IO] : q[`Q_MEM];
      vec = (ca >= `NMI_VEC_LO) && (ca <= `NMI_VEC_HI);
      cmp_match = ((ca == a) && dir_ok && spc_ok) || (vec && inta);
    end
  endfunction

  // Comparator setup; clearing a comparator drops its arm bit
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_en_q  <= 3'h0;
      cmp_arm_q <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        cmp_addr_q[i] <= {`ADDR_W{1'b0}};
        cmp_qual_q[i] <= 4'h0;
      end
    end else if (BK_WE && (BK_SEL < 2'h3)) begin
      cmp_en_q[BK_SEL]   <= BK_EN;
      cmp_arm_q[BK_SEL]  <= BK_EN && BK_ARM && (BK_SEL != 2'h0);
      cmp_addr_q[BK_SEL] <= BK_ADDR;
      cmp_qual_q[BK_SEL] <= BK_QUAL;
    end
  end

  // Hits and chain evaluation
  always @* begin
    chain = {1'b0, cmp_arm_q[2] & cmp_en_q[2], cmp_arm_q[1] & cmp_en_q[1]};
    for (j = 0; j < 3; j = j + 1) begin
      hit[j] = BUS_STB && cmp_en_q[j] &&
               cmp_match(cmp_addr_q[j], cmp_qual_q[j], BUS_ADDR, BUS_WR, BUS_IO, INTA_CYC);
    end
    // A comparator that is armed only counts once its upstream has armed it
    armed_d = ARMED_Q;
    fire    = 3'h0;
    for (j = 0; j < 3; j = j + 1) begin
      if (hit[j] && (!cmp_arm_q[j] || ARMED_Q[j])) begin
        if (chain[j]) begin
          armed_d = armed_d | (3'h2 << j);
        end else begin
          fire[j] = 1'b1;
        end
      end
    end
    // Drop stale arming when a chain link is cleared
    armed_d = armed_d & cmp_arm_q;
    if (|fire) begin
      armed_d = 3'h0;
    end
  end

  // Break, trace capture and arming state
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BREAK_Q      <= 1'b0;
      TRACE_ADDR_Q <= {`ADDR_W{1'b0}};
      TRACE_WR_Q   <= 1'b0;
      TRACE_IO_Q   <= 1'b0;
      ARMED_Q      <= 3'h0;
    end else begin
      ARMED_Q <= armed_d;
      if (|fire) begin
        BREAK_Q      <= 1'b1;
        TRACE_ADDR_Q <= BUS_ADDR;
        TRACE_WR_Q   <= BUS_WR;
        TRACE_IO_Q   <= BUS_IO;
      end else if (BK_CLR_TRIG) begin
        BREAK_Q <= 1'b0; // New break wins over the clear
      end
    end
  end

  // Block map lookup and update
  map_mem u_map (
    .CLK        (CLK),
    .RST_N      (RST_N),
    .rd_blk     (BUS_ADDR[`ADDR_W-1:`BLK_LSB]),
    .rd_alloc_q (map_alloc),
    .rd_slow_q  (map_slow),
    .wr_en      (MAP_WE),
    .wr_blk     (MAP_BLK),
    .wr_alloc   (MAP_ALLOC),
    .wr_attr_en (MAP_ATTR_EN),
    .wr_slow    (MAP_SLOW),
    .clr_all    (MAP_DEAL_ALL)
  );

  // Wait request only for allocated slow memory cycles
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stb_q      <= 1'b0;
      MAP_HIT_Q  <= 1'b0;
      WAIT_REQ_Q <= 1'b0;
    end else begin
      stb_q      <= BUS_STB && !BUS_IO;
      MAP_HIT_Q  <= stb_q && map_alloc;
      WAIT_REQ_Q <= stb_q && map_alloc && map_slow;
    end
  end

  // Processor register state at reset
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CODE_SEG_Q            <= `CS_RESET;
      INSTRUCTION_POINTER_Q <= `SEG_RESET;
      DATA_SEGMENT_Q        <= `SEG_RESET;
      EXTRA_SEGMENT_Q       <= `SEG_RESET;
      STACK_SEG_Q           <= `SEG_RESET;
      FLAGS_Q               <= `SEG_RESET;
    end
  end

  // Pin observation through three flops, no write path
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_q             <= 3'h0;
      pin_s2_q             <= 3'h0;
      MASKABLE_IRQ_INPUT_Q <= 1'b0;
      NMI_IN_Q             <= 1'b0;
      TEST_IN_Q            <= 1'b0;
    end else begin
      pin_s1_q             <= {TEST_PIN, NMI_PIN, MASKABLE_IRQ_PIN};
      pin_s2_q             <= pin_s1_q;
      MASKABLE_IRQ_INPUT_Q <= pin_s2_q[0];
      NMI_IN_Q             <= pin_s2_q[1];
      TEST_IN_Q            <= pin_s2_q[2];
    end
  end
endmodule // ice_break_map

// File: testbench/ice_break_map_monitor.sv
/*
 Checker module for the break and map block.
 Bound to the block's top module; sees its ports only.
*/
`timescale 1ns/100ps
module ice_break_map_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Inputs watched
  input wire logic        BUS_STB,
  input wire logic        BUS_IO,
  input wire logic        BK_CLR_TRIG,
  input wire logic        NMI_PIN,
  // Outputs watched
  input wire logic        BREAK_Q,
  input wire logic [2:0]  ARMED_Q,
  input wire logic        MAP_HIT_Q,
  input wire logic        WAIT_REQ_Q,
  input wire logic        NMI_IN_Q,
  input wire logic [15:0] CODE_SEG_Q
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Cycle shapes
  sequence s_io; BUS_STB && BUS_IO; endsequence
  sequence s_brk; $rose(BREAK_Q); endsequence
  // Reset state and map answers
  property p_cs; CODE_SEG_Q == 16'hffff; endproperty
  a_cs: assert property (p_cs) else $error("code seg");
  property p_io; s_io |-> ##2 !MAP_HIT_Q && !WAIT_REQ_Q; endproperty
  a_io: assert property (p_io) else $error("io hit");
  property p_hit; MAP_HIT_Q || WAIT_REQ_Q |-> $past(BUS_STB, 2) && !$past(BUS_IO, 2); endproperty
  a_hit: assert property (p_hit) else $error("map cause");
  // Break and arming
  property p_stay; BREAK_Q && !BK_CLR_TRIG |=> BREAK_Q; endproperty
  a_stay: assert property (p_stay) else $error("break lost");
  property p_clr; BREAK_Q && BK_CLR_TRIG && !BUS_STB |=> !BREAK_Q; endproperty
  a_clr: assert property (p_clr) else $error("break kept");
  property p_brk; s_brk |-> $past(BUS_STB) && ARMED_Q == 3'h0; endproperty
  a_brk: assert property (p_brk) else $error("break cause");
  property p_arm; $rose(ARMED_Q[2]) |-> $past(BUS_STB); endproperty
  a_arm: assert property (p_arm) else $error("arm cause");
  // Pin follows after three edges
  property p_pin; $stable(NMI_PIN)[*4] |-> NMI_IN_Q == NMI_PIN; endproperty
  a_pin: assert property (p_pin) else $error("pin");
endmodule // ice_break_map_chk
bind ice_break_map ice_break_map_chk u_chk (.*);

// File: testbench/proc_bus_model.sv
/*
 Emulated processor bus: one strobed cycle per call.
 Assumes the bench clock; released address, write and I/O lines show inverted values, interrupt acknowledge drops to 0.
*/
`timescale 1ns/100ps
module proc_bus_model (
  // Clock
  input  wire logic   clk,
  // Bus cycle
  output logic        stb = 0,
  output logic [19:0] addr = 0,
  output logic        wr = 0,
  output logic        io = 0,
  output logic        inta = 0
);
  // Idle gap, strobe for one cycle, then release
  task automatic cycle(logic [19:0] a, bit w, bit i, bit n, int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    {stb, addr, wr, io, inta} <= {1'b1, a, w, i, n};
    @(posedge clk);
    {stb, addr, wr, io, inta} <= {1'b0, ~a, ~w, ~i, 1'b0};
  endtask
endmodule // proc_bus_model

// File: testbench/ice_break_map_tb.sv
/*
 Bench for the break and map block with a reference model.
 Assumes the bus model file and the bound checker.
*/
`timescale 1ns/100ps
`include "ice_consts.vh"
module ice_break_map_tb;
  logic CLK = 0, RST_N = 0, BK_WE = 0, BK_EN = 0, BK_ARM = 0, BK_CLR_TRIG = 0, MAP_WE = 0, MAP_ALLOC = 0;
  logic MAP_ATTR_EN = 0, MAP_SLOW = 0, MAP_DEAL_ALL = 0, MASKABLE_IRQ_PIN = 0, NMI_PIN = 0, TEST_PIN = 0;
  logic BUS_STB, BUS_WR, BUS_IO, INTA_CYC, BREAK_Q, TRACE_WR_Q, TRACE_IO_Q, MAP_HIT_Q, WAIT_REQ_Q;
  logic MASKABLE_IRQ_INPUT_Q, NMI_IN_Q, TEST_IN_Q;
  logic [1:0] BK_SEL = 0;
  logic [2:0] ARMED_Q;
  logic [3:0] BK_QUAL = 0;
  logic [7:0] MAP_BLK = 0;
  logic [19:0] BUS_ADDR, BK_ADDR = 0, TRACE_ADDR_Q;
  logic [15:0] CODE_SEG_Q, INSTRUCTION_POINTER_Q, DATA_SEGMENT_Q, EXTRA_SEGMENT_Q, STACK_SEG_Q, FLAGS_Q;
  // Reference model state
  int mismatches = 0, checks = 0, cycles = 0, men[3], marm[3], arm[3], mbrk = 0;
  logic [19:0] ma[3];
  logic [3:0] mq[3];
  bit al[256], sl[256];
  ice_break_map u_ice_break_map (.*);
  proc_bus_model u_proc_bus_model (.clk(CLK), .stb(BUS_STB), .addr(BUS_ADDR), .wr(BUS_WR), .io(BUS_IO), .inta(INTA_CYC));
  // Clock and hang guard
  initial forever #20 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Comparator write; select 3 is ignored
  task automatic setbk(int s, int en, logic [19:0] a, logic [3:0] q, int am);
    @(posedge CLK);
    {BK_WE, BK_SEL, BK_EN, BK_ADDR, BK_QUAL, BK_ARM} <= {1'b1, s[1:0], en[0], a, q, am[0]};
    @(posedge CLK);
    BK_WE <= 0;
    if (s < 3) begin
      {men[s], ma[s], mq[s], marm[s]} = {en, a, q, 32'(en && am && s > 0)};
      arm[s] = arm[s] && marm[s];
    end
  endtask
  // Map update or release of all blocks
  task automatic map(int b, int alc, int ae, int slw, int all);
    @(posedge CLK);
    {MAP_WE, MAP_BLK, MAP_ALLOC, MAP_ATTR_EN, MAP_SLOW, MAP_DEAL_ALL} <= {!all[0], b[7:0], alc[0], ae[0], slw[0], all[0]};
    @(posedge CLK);
    {MAP_WE, MAP_DEAL_ALL} <= 2'h0;
    if (all) al = '{default: 0};
    else al[b] = alc[0];
    if (ae && !all) sl[b] = slw[0];
  endtask
  // One bus cycle with predicted break, arming and map answer
  task automatic cyc(logic [19:0] a, bit w, bit io, bit ia);
    int f, h, na[3];
    f = 0;
    na = arm;
    for (int i = 0; i < 3; i++) begin
      h = men[i] && (ma[i] == a && mq[i][w] && mq[i][2 + io] || ia && ma[i] >= `NMI_VEC_LO && ma[i] <= `NMI_VEC_HI)
          && (!marm[i] || arm[i]);
      if (h && i < 2 && marm[i + 1]) na[i + 1] = 1;
      else if (h) f = 1;
    end
    u_proc_bus_model.cycle(a, w, io, ia, $urandom_range(2));
    #1;
    if (f) begin
      mbrk = 1;
      na = '{0, 0, 0};
      check("trace", TRACE_ADDR_Q, a);
      check("trace wr", TRACE_WR_Q, w);
      check("trace io", TRACE_IO_Q, io);
    end
    arm = na;
    check("break", BREAK_Q, mbrk);
    check("armed", ARMED_Q[2:1], {arm[2][0], arm[1][0]});
    @(posedge CLK);
    #1;
    check("hit", MAP_HIT_Q, !io && al[a[19:12]]);
    check("wait", WAIT_REQ_Q, !io && al[a[19:12]] && sl[a[19:12]]);
  endtask
  task clr;
    @(posedge CLK);
    BK_CLR_TRIG <= 1;
    @(posedge CLK);
    BK_CLR_TRIG <= 0;
    #1;
    mbrk = 0;
    check("clear", BREAK_Q, 0);
  endtask
  // Main sequence
  initial begin
    static int cs[5] = '{3, 2, 1, 2, 3};
    void'($urandom(32'ha998));
    repeat (5) @(posedge CLK);
    RST_N <= 1;
    #1;
    check("regs", {CODE_SEG_Q, |{INSTRUCTION_POINTER_Q, DATA_SEGMENT_Q, EXTRA_SEGMENT_Q, STACK_SEG_Q, FLAGS_Q}}, 17'h1fffe);
    for (int b = 0; b < 4; b++) map(b, 1, 0, 0, 0);
    map(8, 1, 1, 1, 0);
    repeat (12) cyc({4'($urandom_range(9)), 16'($urandom)}, 1'($urandom), 1'($urandom), 0);
    map(8, 0, 0, 0, 0);
    map(8, 1, 0, 0, 0);
    cyc(20'h08004, 0, 0, 0);
    map(0, 0, 0, 0, 1);
    cyc(20'h01000, 0, 0, 0);
    map(8, 1, 0, 0, 0);
    cyc(20'h08010, 1, 0, 0);
    map(8, 1, 1, 0, 0);
    cyc(20'h08020, 0, 0, 0);
    for (int q = 0; q < 16; q++) begin
      setbk(0, 1, 20'h1c0f0, q[3:0], 0);
      for (int k = 0; k < 4; k++) cyc(20'h1c0f0, k[0], k[1], 0);
      if (mbrk) clr;
    end
    for (int i = 0; i < 20; i++) cyc(20'h1c0f0 ^ (20'h1 << i), 0, 0, 0);
    setbk(3, 1, 20'h1c0f1, 4'hf, 0);
    cyc(20'h1c0f1, 0, 0, 0);
    for (int m = 1; m < 4; m++) begin
      setbk(0, 1, 20'h00100, 4'hf, 0);
      setbk(1, 1, 20'h00200, 4'hf, m != 2);
      setbk(2, m != 1, 20'h00300, 4'hf, 1);
      foreach (cs[j]) cyc(20'(cs[j] << 8), 0, 0, 0);
      clr;
    end
    cyc(20'h00100, 0, 0, 0);
    setbk(1, 0, 20'h00200, 4'hf, 1);
    cyc(20'h00100, 0, 0, 0);
    clr;
    setbk(2, 1, 20'h0000a, 4'hf, 0);
    cyc(20'h3f000, 0, 0, 0);
    cyc(20'h3f000, 0, 0, 1);
    clr;
    repeat (6) begin
      @(posedge CLK);
      {MASKABLE_IRQ_PIN, NMI_PIN, TEST_PIN} <= 3'($urandom);
      repeat (4) @(posedge CLK);
      #1;
      check("pins", {MASKABLE_IRQ_INPUT_Q, NMI_IN_Q, TEST_IN_Q}, {MASKABLE_IRQ_PIN, NMI_PIN, TEST_PIN});
    end
    report_and_stop;
  end
endmodule // ice_break_map_tb
